/* hw/wdt_map.vh */
// Register map, field layout, reset values and timing constants of the watchdog block.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define WDT_IDX_CTRL      8'h34
`define WDT_IDX_KEY       8'h35
`define WDT_IDX_STATUS    8'h36
`define WDT_ADDR_CTRL     8'hD0
`define WDT_ADDR_KEY      8'hD4
`define WDT_ADDR_STATUS   8'hD8

`define WDT_BIT_ACTION    0
`define WDT_BIT_PER_LO    1
`define WDT_BIT_PER_HI    2
`define WDT_BIT_ENABLE    3
`define WDT_BIT_TRAP_ACT  4
`define WDT_BIT_TRAP_RAM  5

`define WDT_RST_ACTION    1'h1
`define WDT_RST_PERIOD    2'h0
`define WDT_RST_ENABLE    1'h1
`define WDT_RST_TRAP_ACT  1'h1
`define WDT_RST_TRAP_RAM  1'h1

`define WDT_KEY_CLEAR     8'h4E
`define WDT_KEY_DISABLE   8'hB1
`define WDT_KEY_TRAP      8'hD2

`define WDT_FC_LOG_MAX    25
`define WDT_FS_LOG_MAX    17
`define WDT_LOG_STEP      2
`define WDT_QTR_LOG       2
`define WDT_CNT_LAST      2'h3

`define WDT_RST_HOLD_FC   24
`define WDT_FC_PER_CLK    1

`define WDT_RESP_OKAY     2'h0
`define WDT_RESP_SLVERR   2'h2

`endif

/* hw/wdt_rst_stretch.v */
// Stretches a one-cycle reset request into a bounded low drive of the reset pin.
`timescale 1ns/10ps
`include "wdt_map.vh"
module wdt_rst_stretch #(
    parameter HOLD_CYC = `WDT_RST_HOLD_FC / `WDT_FC_PER_CLK
) (
    clk_sys,
    rst_n,
    fire,
    pin_oe,
    busy
);
    input  wire clk_sys;
    input  wire rst_n;
    input  wire fire;
    output wire pin_oe;
    output wire busy;

    reg  [5:0] cnt_q;
    reg  [5:0] cnt_d;

    // The hold never exceeds HOLD_CYC cycles, a retrigger inside it does not extend it.
    always @* begin
        cnt_d = cnt_q;
        if (cnt_q != 6'h00) begin
            cnt_d = cnt_q - 6'h01;
        end else if (fire) begin
            cnt_d = HOLD_CYC[5:0];
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign pin_oe = (cnt_q != 6'h00);
    assign busy   = pin_oe;
endmodule // wdt_rst_stretch

/* hw/wdt_core.v */
// Watchdog timer with divider, two-stage binary counter and AXI4-Lite register access.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "wdt_map.vh"
module wdt_core #(
    parameter FC_LOG_MAX = `WDT_FC_LOG_MAX,
    parameter FS_LOG_MAX = `WDT_FS_LOG_MAX
) (
    clk_sys,
    rst_n,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    fs_tick,
    divider_clock_select,
    slow_mode,
    stop_mode,
    warmup_active,
    idle_mode,
    sleep_mode,
    wd_interrupt_request,
    wd_reset_request,
    reset_pin_i,
    reset_pin_o,
    reset_pin_oe,
    internal_reset_n,
    ram_trap_select,
    trap_action_select
);
    input  wire        clk_sys;
    input  wire        rst_n;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output wire [1:0]  s_axi_bresp;
    output wire        s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output wire [31:0] s_axi_rdata;
    output wire [1:0]  s_axi_rresp;
    output wire        s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire        fs_tick;
    input  wire        divider_clock_select;
    input  wire        slow_mode;
    input  wire        stop_mode;
    input  wire        warmup_active;
    input  wire        idle_mode;
    input  wire        sleep_mode;
    output wire        wd_interrupt_request;
    output wire        wd_reset_request;
    input  wire        reset_pin_i;
    output wire        reset_pin_o;
    output wire        reset_pin_oe;
    output wire        internal_reset_n;
    output wire        ram_trap_select;
    output wire        trap_action_select;

    localparam DIV_W = FC_LOG_MAX - `WDT_QTR_LOG;

    // Quarter-period mask of the divider for the selected source and period code.
    function [DIV_W-1:0] qtr_mask;
        input       fs_src;
        input [1:0] code;
        integer     sh;
        begin
            sh = (fs_src ? FS_LOG_MAX : FC_LOG_MAX) - `WDT_QTR_LOG - `WDT_LOG_STEP * code;
            qtr_mask = ~({DIV_W{1'b1}} << sh);
        end
    endfunction

    // Register offset decode shared by the write and read paths.
    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'h0})
                `WDT_ADDR_CTRL:   reg_sel = 2'h1;
                `WDT_ADDR_KEY:    reg_sel = 2'h2;
                `WDT_ADDR_STATUS: reg_sel = 2'h3;
                default:          reg_sel = 2'h0;
            endcase
        end
    endfunction

    // Write channel state.
    reg  [7:0]  awaddr_q;
    reg         aw_have_q;
    reg  [7:0]  wdata_q;
    reg         wstrb0_q;
    reg         w_have_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    // Read channel state.
    reg         rvalid_q;
    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;
    // Watchdog state.
    reg         action_q;
    reg  [1:0]  period_q;
    reg         enable_q;
    reg         run_q;
    reg         trap_act_q;
    reg         trap_ram_q;
    reg         trap_ram_live_q;
    reg  [DIV_W-1:0] div_q;
    reg  [1:0]  bin_q;
    reg         irq_q;
    reg         rst_req_q;

    wire        wr_go;
    wire [1:0]  wr_sel;
    wire        wr_ctrl;
    wire        wr_key;
    wire        key_clear;
    wire        key_disable;
    wire        key_trap;
    wire        pause;
    wire        fs_src;
    wire        src_tick;
    wire [DIV_W-1:0] mask;
    wire        qtr_tick;
    wire        overflow;
    wire        reinit;
    wire        hold_busy;
    wire [31:0] status_word;
    wire [1:0]  rd_sel;

    // Bus writes complete once address and data are both held and no response is pending.
    assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
    assign wr_sel  = reg_sel(awaddr_q);
    assign wr_ctrl = wr_go && wstrb0_q && (wr_sel == 2'h1);
    assign wr_key  = wr_go && wstrb0_q && (wr_sel == 2'h2);

    assign key_clear   = wr_key && (wdata_q == `WDT_KEY_CLEAR);
    assign key_disable = wr_key && (wdata_q == `WDT_KEY_DISABLE);
    assign key_trap    = wr_key && (wdata_q == `WDT_KEY_TRAP);

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            awaddr_q  <= 8'h00;
            aw_have_q <= 1'b0;
            wdata_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `WDT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q  <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_sel == 2'h0) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // The control and key registers read as zero; only the status word carries state.
    assign status_word = {26'h0000000, reset_pin_i, trap_ram_live_q, bin_q, action_q, run_q};
    assign rd_sel      = reg_sel(s_axi_araddr);

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `WDT_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= (rd_sel == 2'h3) ? status_word : 32'h00000000;
                rresp_q  <= (rd_sel == 2'h0) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Counting source and quarter-period tick.
    assign pause    = stop_mode || warmup_active || idle_mode || sleep_mode;
    assign fs_src   = slow_mode || divider_clock_select;
    assign src_tick = fs_src ? fs_tick : 1'b1;
    assign mask     = qtr_mask(fs_src, period_q);
    assign qtr_tick = src_tick && !pause && run_q && ((div_q & mask) == mask);
    assign overflow = qtr_tick && (bin_q == `WDT_CNT_LAST) && !key_clear;

    // A watchdog reset reinitialises the block's own control state as the chip reset would.
    assign reinit = !rst_n || rst_req_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            div_q <= {DIV_W{1'b0}};
        end else if (src_tick && !pause) begin
            div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys) begin
        if (reinit) begin
            action_q        <= `WDT_RST_ACTION;
            period_q        <= `WDT_RST_PERIOD;
            enable_q        <= `WDT_RST_ENABLE;
            run_q           <= `WDT_RST_ENABLE;
            trap_act_q      <= `WDT_RST_TRAP_ACT;
            trap_ram_q      <= `WDT_RST_TRAP_RAM;
            trap_ram_live_q <= `WDT_RST_TRAP_RAM;
            bin_q           <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                action_q   <= action_q & wdata_q[`WDT_BIT_ACTION];
                period_q   <= wdata_q[`WDT_BIT_PER_HI:`WDT_BIT_PER_LO];
                enable_q   <= wdata_q[`WDT_BIT_ENABLE];
                trap_act_q <= wdata_q[`WDT_BIT_TRAP_ACT];
                trap_ram_q <= wdata_q[`WDT_BIT_TRAP_RAM];
                if (wdata_q[`WDT_BIT_ENABLE]) begin
                    run_q <= 1'b1;
                end
            end
            if (key_disable && !enable_q) begin
                run_q <= 1'b0;
            end
            if (key_trap) begin
                trap_ram_live_q <= trap_ram_q;
            end
            if (!run_q || key_clear || (key_disable && !enable_q)) begin
                bin_q <= 2'h0;
            end else if (qtr_tick) begin
                bin_q <= bin_q + 2'h1;
            end
        end
    end

    // Overflow outcome pulses, registered one cycle after the overflow tick.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_q     <= 1'b0;
            rst_req_q <= 1'b0;
        end else begin
            irq_q     <= overflow && !action_q;
            rst_req_q <= overflow && action_q && !rst_req_q;
        end
    end

    wdt_rst_stretch u_stretch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .fire    (rst_req_q),
        .pin_oe  (reset_pin_oe),
        .busy    (hold_busy)
    );

    // The interrupt has no mask here; the core must take it whatever its master flag says.
    assign wd_interrupt_request = irq_q;
    assign wd_reset_request     = rst_req_q;
    assign reset_pin_o          = 1'b0;
    assign internal_reset_n     = !hold_busy;
    assign ram_trap_select      = trap_ram_live_q;
    assign trap_action_select   = trap_act_q;
endmodule // wdt_core

/* testbench/wdt_core_chk.sv */
// Port-level assertions for the watchdog core, bound into every instance.
`timescale 1ns/10ps
module wdt_core_chk (
    input logic clk_sys,
    input logic rst_n,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic stop_mode,
    input logic wd_interrupt_request,
    input logic wd_reset_request,
    input logic reset_pin_o,
    input logic reset_pin_oe,
    input logic internal_reset_n
);
    logic [4:0] hold_q;
    logic [4:0] hold_d;
    // Counting the low drive lets the length be checked without a long repetition.
    assign hold_d = reset_pin_oe ? hold_q + 5'h01 : 5'h00;
    always @(posedge clk_sys)
        hold_q <= rst_n ? hold_d : 5'h00;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_pin_low;
        reset_pin_oe && !internal_reset_n && !reset_pin_o;
    endsequence
    sequence s_hold;
        s_pin_low [*8];
    endsequence
    a_pin_hold: assert property (wd_reset_request |=> s_hold)
        else $error("reset pin not driven after reset request");
    a_hold_exact: assert property ($fell(reset_pin_oe) |-> hold_q == 5'h18)
        else $error("reset drive length wrong");
    a_hold_bound: assert property (hold_q <= 5'h18)
        else $error("reset drive too long");
    a_oe_tracks: assert property (reset_pin_oe == !internal_reset_n)
        else $error("pin drive and internal reset disagree");
    a_irq_gap: assert property (wd_interrupt_request |=> !wd_interrupt_request [*7])
        else $error("interrupts closer than shortest period");
    a_req_exclusive: assert property (!(wd_interrupt_request && wd_reset_request))
        else $error("interrupt and reset request together");
    a_pause_quiet: assert property ($past(stop_mode) |-> !wd_interrupt_request && !wd_reset_request)
        else $error("overflow while paused");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule // wdt_core_chk
bind wdt_core wdt_core_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .stop_mode(stop_mode),
    .wd_interrupt_request(wd_interrupt_request), .wd_reset_request(wd_reset_request),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .internal_reset_n(internal_reset_n));

/* testbench/watchdog_timer_block_tb_top.sv */
// Self-checking bench for the watchdog core driven over its register bus.
`timescale 1ns/10ps
`include "wdt_map.vh"
module watchdog_timer_block_tb_top;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [1:0] resp;
    } wdt_row_t;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_wvalid = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    logic        fs_tick = 1'b0;
    logic [1:0]  fs_div = 2'h0;
    logic        divider_clock_select = 1'b0;
    logic        slow_mode = 1'b0;
    logic [3:0]  pause_q = 4'h0;
    logic        reset_pin_i = 1'b1;
    wire         wd_interrupt_request, wd_reset_request, reset_pin_oe, ram_trap_select, trap_action_select;
    logic [1:0]  bus_resp;
    logic [7:0]  bus_data;
    logic        ev_seen;
    int          ev_cyc, t0, n, cyc = 0, num_errors = 0, samples_checked = 0;
    wdt_row_t    rows [8] = '{
        '{1'b0, `WDT_ADDR_STATUS, 8'h33, 2'h0},
        '{1'b0, `WDT_ADDR_CTRL, 8'h00, 2'h0},
        '{1'b0, `WDT_ADDR_KEY, 8'h00, 2'h0},
        '{1'b0, 8'h40, 8'h00, 2'h2},
        '{1'b1, 8'h40, 8'h00, 2'h2},
        '{1'b1, `WDT_ADDR_KEY, 8'h77, 2'h0},
        '{1'b1, `WDT_ADDR_KEY, `WDT_KEY_DISABLE, 2'h0},
        '{1'b0, `WDT_ADDR_STATUS, 8'h33, 2'h0}};

    // Shortened period logs keep the longest slow-clock period at 2048 cycles.
    wdt_core #(.FC_LOG_MAX(9), .FS_LOG_MAX(9)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .fs_tick(fs_tick),
        .divider_clock_select(divider_clock_select), .slow_mode(slow_mode), .stop_mode(pause_q[0]),
        .warmup_active(pause_q[1]), .idle_mode(pause_q[2]), .sleep_mode(pause_q[3]),
        .wd_interrupt_request(wd_interrupt_request), .wd_reset_request(wd_reset_request),
        .reset_pin_i(reset_pin_i), .reset_pin_o(), .reset_pin_oe(reset_pin_oe), .internal_reset_n(),
        .ram_trap_select(ram_trap_select), .trap_action_select(trap_action_select));

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        fs_div <= fs_div + 2'h1;
        fs_tick <= fs_div == 2'h3;
        reset_pin_i <= !reset_pin_oe;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Ready is sampled at the falling edge, where it already equals its value at the next rising edge.
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_hs, w_hs, b_hs;
        int   k;
        b_hs = 1'b0;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!b_hs && k < 100) begin
            @(negedge clk_sys);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            bus_resp = b_hs ? s_axi_bresp : 2'h3;
            @(posedge clk_sys);
            if (aw_hs)
                s_axi_awvalid <= 1'b0;
            if (w_hs)
                s_axi_wvalid <= 1'b0;
            k++;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic ar_hs, r_hs;
        int   k;
        r_hs = 1'b0;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_hs && k < 100) begin
            @(negedge clk_sys);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            bus_resp = r_hs ? s_axi_rresp : 2'h3;
            bus_data = s_axi_rdata[7:0];
            @(posedge clk_sys);
            if (ar_hs)
                s_axi_arvalid <= 1'b0;
            k++;
        end
    endtask

    task automatic wait_ev(input logic sel, input int lim, input logic exp);
        int k;
        k = 0;
        ev_seen = 1'b0;
        while (!ev_seen && k < lim) begin
            @(negedge clk_sys);
            ev_seen = sel ? wd_reset_request : wd_interrupt_request;
            ev_cyc = cyc;
            @(posedge clk_sys);
            k++;
        end
        chk("event", ev_seen, exp);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            if (rows[i].wr)
                axi_wr(rows[i].addr, rows[i].data);
            else
                axi_rd(rows[i].addr);
            chk("resp", bus_resp, rows[i].resp);
            if (!rows[i].wr && rows[i].resp == 2'h0)
                chk("rdata", bus_data & 8'hF3, rows[i].data);
        end
        axi_wr(`WDT_ADDR_CTRL, 8'h3F);
        wait_ev(1'b1, 100, 1'b1);
        n = 0;
        repeat (30) begin
            @(negedge clk_sys);
            n += reset_pin_oe;
        end
        chk("hold", n, 24);
        @(posedge clk_sys);
        axi_rd(`WDT_ADDR_STATUS);
        chk("reinit", bus_data & 8'hF3, 8'h33);
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 4; c++) begin
                divider_clock_select <= s == 1;
                slow_mode <= s == 2;
                axi_wr(`WDT_ADDR_CTRL, 8'h38 | {5'h00, c[1:0], 1'b0});
                wait_ev(1'b0, 5000, 1'b1);
                t0 = ev_cyc;
                wait_ev(1'b0, 5000, 1'b1);
                chk("period", ev_cyc - t0, (1 << (9 - 2 * c)) * (s > 0 ? 4 : 1));
            end
        end
        axi_wr(`WDT_ADDR_CTRL, 8'h3F);
        axi_rd(`WDT_ADDR_STATUS);
        chk("action", bus_data & 8'h03, 8'h01);
        divider_clock_select <= 1'b0;
        slow_mode <= 1'b0;
        axi_wr(`WDT_ADDR_CTRL, 8'h38);
        wait_ev(1'b0, 2000, 1'b1);
        t0 = ev_cyc;
        repeat (150) @(posedge clk_sys);
        axi_wr(`WDT_ADDR_KEY, `WDT_KEY_CLEAR);
        wait_ev(1'b0, 2000, 1'b1);
        chk("clear", ev_cyc - t0, 640);
        axi_wr(`WDT_ADDR_CTRL, 8'h3E);
        for (int m = 0; m < 4; m++) begin
            wait_ev(1'b0, 100, 1'b1);
            t0 = ev_cyc;
            pause_q <= 4'h1 << m;
            repeat (20) @(posedge clk_sys);
            pause_q <= 4'h0;
            wait_ev(1'b0, 100, 1'b1);
            chk("pause", ev_cyc - t0, 28);
        end
        axi_wr(`WDT_ADDR_KEY, `WDT_KEY_CLEAR);
        axi_wr(`WDT_ADDR_CTRL, 8'h06);
        chk("trap_act", trap_action_select, 1'b0);
        axi_rd(`WDT_ADDR_STATUS);
        chk("still_on", bus_data & 8'h01, 8'h01);
        axi_wr(`WDT_ADDR_KEY, `WDT_KEY_DISABLE);
        axi_rd(`WDT_ADDR_STATUS);
        chk("off", bus_data & 8'h0D, 8'h00);
        chk("ram_sel", ram_trap_select, 1'b1);
        axi_wr(`WDT_ADDR_KEY, `WDT_KEY_TRAP);
        chk("ram_sel", ram_trap_select, 1'b0);
        wait_ev(1'b0, 300, 1'b0);
        // Stop mode is entered here once the watchdog is disabled, as software must do.
        pause_q <= 4'h1;
        repeat (5) @(posedge clk_sys);
        pause_q <= 4'h0;
        @(posedge clk_sys);
        axi_wr(`WDT_ADDR_CTRL, 8'h0E);
        wait_ev(1'b0, 100, 1'b1);
        print_verdict;
    end

    // All scenarios together need roughly 14000 cycles, so this leaves ample margin.
    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        print_verdict;
    end
endmodule // watchdog_timer_block_tb_top
